// *** ptos_top.sv ***
`timescale 1ns/1ns
module ptos_top #(
    parameter int DW = ptos_pkg::DATA_W
) (
    // clock, reset, enable
    input  wire logic                       ref_clk,
    input  wire logic                       rst,
    input  wire logic                       ce,
    // register port
    input  wire logic [ptos_pkg::ADDR_W-1:0] addr,
    input  wire logic [DW-1:0]              wr_data,
    input  wire logic                       wr_stb,
    input  wire logic                       rd_stb,
    output logic [DW-1:0]                   rd_data,
    // block sequencing
    input  wire logic                       block_start,
    input  wire logic                       block_slash,
    input  wire logic                       block_thread,
    input  wire logic                       block_done,
    input  wire logic                       cycle_start,
    output logic                            exec_block,
    output logic                            skip_block,
    output logic                            auto_stop,
    // motion
    input  wire logic                       motion_pulse,
    output logic                            servo_pulse,
    output logic                            coord_pulse,
    output logic [DW-1:0]                   feed_rate,
    output logic [DW-1:0]                   rapid_rate,
    // status echoes
    output logic                            machine_lock_status,
    output logic                            single_block_status,
    output logic                            block_skip_status
);
    import ptos_pkg::*;

    typedef struct packed {
        logic [7:0]    test_mode;
        logic [7:0]    skip_ctl;
        logic [7:0]    rapid_sel;
        logic [7:0]    feed_sel;
        logic [7:0]    cancel_ctl;
        logic [7:0]    lock_ctl;
        logic [7:0]    op_mode;
        logic [DW-1:0] rapid_par;
        logic [DW-1:0] dry_rate;
        logic [DW-1:0] low_rate;
        logic [DW-1:0] prog_feed;
        logic [DW-1:0] ramp_step;
        logic [DW-1:0] feed_target;
        logic [DW-1:0] rapid_rate;
        logic [DW-1:0] rd_data;
        ptos_seq_type  seq;
        logic          thread_blk;
        logic          exec_block;
        logic          skip_block;
        logic          servo_pulse;
        logic          coord_pulse;
        logic          lock_stat;
        logic          single_stat;
        logic          skip_stat;
    } ptos_state_type;

    ptos_state_type s_q;
    ptos_state_type s_d;

    ptos_ramp_if #(.DW(DW)) rif ();

    logic          auto_mdi;
    logic          dry_on;
    logic          single_on;
    logic          skip_on;
    logic          lock_on;
    logic          cancel_on;
    logic          rapid_alt;
    logic [2:0]    rapid_code;
    logic [4:0]    feed_code;
    logic [7:0]    feed_pct;
    logic [7:0]    rapid_pct;
    logic          rapid_low;
    logic [DW+7:0] feed_prod;
    logic [DW+7:0] rapid_prod;
    logic [DW+7:0] feed_quo;
    logic [DW+7:0] rapid_quo;
    logic [7:0]    status_byte;

    // decoded control fields
    always_comb begin
        auto_mdi   = (s_q.op_mode[1:0] == MODE_AUTO) || (s_q.op_mode[1:0] == MODE_MDI);
        dry_on     = s_q.test_mode[BIT_DRY_RUN] && auto_mdi; // R3
        single_on  = s_q.test_mode[BIT_SINGLE_BLK];
        skip_on    = s_q.skip_ctl[BIT_BLOCK_SKIP];
        lock_on    = s_q.lock_ctl[BIT_LOCK];
        cancel_on  = s_q.cancel_ctl[BIT_CANCEL];
        rapid_alt  = s_q.rapid_sel[BIT_RAPID_ALT];
        rapid_code = s_q.rapid_sel[2:0];
        feed_code  = s_q.feed_sel[4:0];
    end

    // feed override percentage
    always_comb begin
        if (cancel_on) begin
            feed_pct = PCT_FULL; // R16
        end else if (feed_code > FEED_CODE_MAX) begin
            feed_pct = PCT_MAX; // R18
        end else begin
            feed_pct = 8'({3'h0, feed_code} * FEED_STEP_PCT); // R15
        end
    end

    // rapid override percentage, never touched by cancel
    always_comb begin
        rapid_low = 1'b0;
        rapid_pct = PCT_FULL; // R17
        if (rapid_alt) begin
            if (rapid_code <= ALT_CODE_MAX) begin
                rapid_pct = 8'({5'h00, rapid_code} * PCT_ALT_STEP); // R12
            end else begin
                rapid_pct = PCT_FULL; // R18
            end
        end else begin
            unique case (rapid_code)
                3'h0: begin
                    rapid_low = 1'b1; // R13
                    rapid_pct = 8'h00;
                end
                3'h1: rapid_pct = PCT_DEF_1; // R12
                3'h2: rapid_pct = PCT_DEF_2; // R12
                default: rapid_pct = PCT_FULL; // R18
            endcase
        end
    end

    // scaled rates
    always_comb begin
        feed_prod  = {8'h00, s_q.prog_feed} * {{DW{1'b0}}, feed_pct};
        rapid_prod = {8'h00, s_q.rapid_par} * {{DW{1'b0}}, rapid_pct}; // R14
        feed_quo   = feed_prod / {{DW{1'b0}}, PCT_FULL};
        rapid_quo  = rapid_prod / {{DW{1'b0}}, PCT_FULL};
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[BIT_SKIP_STATUS] = s_q.skip_stat;
        status_byte[BIT_LOCK_STATUS] = s_q.lock_stat;
        status_byte[BIT_SINGLE_STATUS] = s_q.single_stat;
    end

    // next state
    always_comb begin
        s_d = s_q;
        s_d.exec_block  = 1'b0;
        s_d.skip_block  = 1'b0;

        // register writes
        if (wr_stb) begin
            unique case (addr)
                OFS_TEST_MODE: s_d.test_mode  = wr_data[7:0];
                OFS_SKIP:      s_d.skip_ctl   = wr_data[7:0];
                OFS_RAPID_SEL: s_d.rapid_sel  = wr_data[7:0];
                OFS_FEED_SEL:  s_d.feed_sel   = wr_data[7:0];
                OFS_CANCEL:    s_d.cancel_ctl = wr_data[7:0];
                OFS_LOCK:      s_d.lock_ctl   = wr_data[7:0];
                OFS_OP_MODE:   s_d.op_mode    = wr_data[7:0];
                OFS_RAPID_PAR: s_d.rapid_par  = wr_data;
                OFS_DRY_RATE:  s_d.dry_rate   = wr_data;
                OFS_LOW_RATE:  s_d.low_rate   = wr_data;
                OFS_PROG_FEED: s_d.prog_feed  = wr_data;
                OFS_RAMP_STEP: s_d.ramp_step  = wr_data;
                default: ;
            endcase
        end

        // register reads, data valid the next cycle only
        s_d.rd_data = '0;
        if (rd_stb) begin
            unique case (addr)
                OFS_STATUS:     s_d.rd_data = {{(DW-8){1'b0}}, status_byte};
                OFS_TEST_MODE:  s_d.rd_data = {{(DW-8){1'b0}}, s_q.test_mode};
                OFS_SKIP:       s_d.rd_data = {{(DW-8){1'b0}}, s_q.skip_ctl};
                OFS_RAPID_SEL:  s_d.rd_data = {{(DW-8){1'b0}}, s_q.rapid_sel};
                OFS_FEED_SEL:   s_d.rd_data = {{(DW-8){1'b0}}, s_q.feed_sel};
                OFS_CANCEL:     s_d.rd_data = {{(DW-8){1'b0}}, s_q.cancel_ctl};
                OFS_LOCK:       s_d.rd_data = {{(DW-8){1'b0}}, s_q.lock_ctl};
                OFS_OP_MODE:    s_d.rd_data = {{(DW-8){1'b0}}, s_q.op_mode};
                OFS_RAPID_PAR:  s_d.rd_data = s_q.rapid_par;
                OFS_DRY_RATE:   s_d.rd_data = s_q.dry_rate;
                OFS_LOW_RATE:   s_d.rd_data = s_q.low_rate;
                OFS_PROG_FEED:  s_d.rd_data = s_q.prog_feed;
                OFS_RAMP_STEP:  s_d.rd_data = s_q.ramp_step;
                OFS_FEED_OUT:   s_d.rd_data = rif.rate;
                OFS_RAPID_OUT:  s_d.rd_data = s_q.rapid_rate;
                OFS_SEQ_STATUS: s_d.rd_data = {{(DW-1){1'b0}}, s_q.seq == PTOS_STOP};
                default:        s_d.rd_data = '0;
            endcase
        end

        // status echoes
        s_d.lock_stat = lock_on; // R1
        s_d.single_stat = single_on; // R8
        s_d.skip_stat = skip_on; // R11

        // machine lock: coordinates follow, servo does not
        s_d.coord_pulse = motion_pulse; // R2
        s_d.servo_pulse = motion_pulse && !lock_on; // R2

        // rate targets
        s_d.feed_target = dry_on ? s_q.dry_rate : feed_quo[DW-1:0]; // R4
        s_d.rapid_rate  = rapid_low ? s_q.low_rate : rapid_quo[DW-1:0]; // R14

        // block sequencing
        unique case (s_q.seq)
            PTOS_RUN: begin
                if (block_start) begin
                    s_d.thread_blk = block_thread;
                    if (auto_mdi && block_slash && skip_on) begin
                        s_d.skip_block = 1'b1; // R10
                    end else begin
                        s_d.exec_block = 1'b1; // R10
                    end
                end
                // threaded blocks run through; stop at the next plain one
                if (block_done && auto_mdi && single_on && !s_q.thread_blk) begin
                    s_d.seq = PTOS_STOP; // R6 R9
                end
            end
            PTOS_STOP: begin
                if (cycle_start) begin
                    s_d.seq = PTOS_RUN; // R7
                end
            end
            default: s_d.seq = PTOS_RUN;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q            <= '0;
            s_q.test_mode  <= RST_BYTE;
            s_q.rapid_sel  <= RST_BYTE;
            s_q.rapid_par  <= RST_RAPID_PAR;
            s_q.dry_rate   <= RST_DRY_RATE;
            s_q.low_rate   <= RST_LOW_RATE;
            s_q.prog_feed  <= RST_PROG_FEED;
            s_q.ramp_step  <= RST_RAMP_STEP;
            s_q.seq        <= PTOS_RUN;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    // feed rate ramps between programmed and dry-run speed
    assign rif.target = s_q.feed_target;
    assign rif.step   = s_q.ramp_step;

    ptos_ramp #(
        .DW (DW)
    ) u_ramp (
        .ref_clk (ref_clk),
        .rst     (rst),
        .ce      (ce),
        .rif     (rif)
    );

    assign rd_data             = s_q.rd_data;
    assign exec_block          = s_q.exec_block;
    assign skip_block          = s_q.skip_block;
    // one-hot stop bit, straight from its flop
    assign auto_stop           = s_q.seq[1];
    assign servo_pulse         = s_q.servo_pulse;
    assign coord_pulse         = s_q.coord_pulse;
    assign feed_rate           = rif.rate;
    assign rapid_rate          = s_q.rapid_rate;
    assign machine_lock_status = s_q.lock_stat;
    assign single_block_status = s_q.single_stat;
    assign block_skip_status   = s_q.skip_stat;
endmodule

// *** ptos_pkg.sv ***
// Notes on behaviour
// R1: lock status echoes machine lock input
// R2: lock withholds servo pulses, coordinates still update
// R3: dry run only in auto or mdi
// R4: dry run uses fixed dry-run feedrate
// R5: dry-run changes ramp the speed
// R6: single block stops after current block
// R7: single block off resumes sequential running; the code leaves stop only on cycle_start
// R8: single block status echoes its input
// R9: thread cutting: stop after next plain block
// R10: block skip drops slash blocks in auto
// R11: block skip status echoes its input
// R12: rapid code decoded per selected scale
// R13: default code 000 uses lowest-level rate
// R14: rapid rate is parameter times override
// R15: feed code gives ten percent per count
// R16: override cancel forces feed to 100%
// R17: cancel leaves rapid override untouched
// R18: clamp feed above 200%, rapid undefined highest
package ptos_pkg;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;

    localparam logic [3:0] OFS_STATUS     = 4'h0;
    localparam logic [3:0] OFS_TEST_MODE  = 4'h1;
    localparam logic [3:0] OFS_SKIP       = 4'h2;
    localparam logic [3:0] OFS_RAPID_SEL  = 4'h3;
    localparam logic [3:0] OFS_FEED_SEL   = 4'h4;
    localparam logic [3:0] OFS_CANCEL     = 4'h5;
    localparam logic [3:0] OFS_LOCK       = 4'h6;
    localparam logic [3:0] OFS_OP_MODE    = 4'h7;
    localparam logic [3:0] OFS_RAPID_PAR  = 4'h8;
    localparam logic [3:0] OFS_DRY_RATE   = 4'h9;
    localparam logic [3:0] OFS_LOW_RATE   = 4'ha;
    localparam logic [3:0] OFS_PROG_FEED  = 4'hb;
    localparam logic [3:0] OFS_RAMP_STEP  = 4'hc;
    localparam logic [3:0] OFS_FEED_OUT   = 4'hd;
    localparam logic [3:0] OFS_RAPID_OUT  = 4'he;
    localparam logic [3:0] OFS_SEQ_STATUS = 4'hf;

    localparam int BIT_SKIP_STATUS = 0;
    localparam int BIT_LOCK_STATUS = 1;
    localparam int BIT_SINGLE_STATUS = 3;
    localparam int BIT_DRY_RUN     = 7;
    localparam int BIT_SINGLE_BLK  = 1;
    localparam int BIT_BLOCK_SKIP  = 0;
    localparam int BIT_RAPID_ALT   = 7;
    localparam int BIT_CANCEL      = 4;
    localparam int BIT_LOCK        = 0;

    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [15:0] RST_RAPID_PAR  = 16'h1000;
    localparam logic [15:0] RST_DRY_RATE   = 16'h0400;
    localparam logic [15:0] RST_LOW_RATE   = 16'h0080;
    localparam logic [15:0] RST_PROG_FEED  = 16'h0400;
    localparam logic [15:0] RST_RAMP_STEP  = 16'h0010;

    localparam logic [1:0] MODE_MANUAL = 2'h0;
    localparam logic [1:0] MODE_AUTO   = 2'h1;
    localparam logic [1:0] MODE_MDI    = 2'h2;

    localparam logic [7:0] PCT_FULL      = 8'h64;
    localparam logic [7:0] PCT_MAX       = 8'hc8;
    localparam logic [7:0] FEED_STEP_PCT = 8'h0a;
    localparam logic [4:0] FEED_CODE_MAX = 5'h14;
    localparam logic [7:0] PCT_DEF_1     = 8'h19;
    localparam logic [7:0] PCT_DEF_2     = 8'h32;
    localparam logic [7:0] PCT_ALT_STEP  = 8'h14;
    localparam logic [2:0] ALT_CODE_MAX  = 3'h5;

    typedef enum logic [1:0] {
        PTOS_RUN  = 2'b01,
        PTOS_STOP = 2'b10
    } ptos_seq_type;
endpackage

// *** ptos_ramp_if.sv ***
`timescale 1ns/1ns
interface ptos_ramp_if #(parameter int DW = 16);
    logic [DW-1:0] target;
    logic [DW-1:0] step;
    logic [DW-1:0] rate;
    modport ctrl (output target, output step, input rate);
    modport ramp (input target, input step, output rate);
endinterface

// *** ptos_ramp.sv ***
`timescale 1ns/1ns
module ptos_ramp #(
    parameter int DW = 16
) (
    // clock, reset and enable
    input  wire logic    ref_clk,
    input  wire logic    rst,
    input  wire logic    ce,
    // rate path
    ptos_ramp_if.ramp    rif
);
    import ptos_pkg::*;

    typedef struct packed {
        logic [DW-1:0] rate;
    } ptos_ramp_state_type;

    ptos_ramp_state_type s_q;
    ptos_ramp_state_type s_d;
    logic [DW-1:0]       gap;

    // walk the rate toward the target, never overshooting
    always_comb begin
        s_d = s_q;
        gap = '0;
        if (rif.target > s_q.rate) begin
            gap = rif.target - s_q.rate;
            s_d.rate = (gap > rif.step) ? s_q.rate + rif.step : rif.target; // R5
        end else if (rif.target < s_q.rate) begin
            gap = s_q.rate - rif.target;
            s_d.rate = (gap > rif.step) ? s_q.rate - rif.step : rif.target; // R5
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else if (ce) begin
            s_q <= s_d;
        end
    end

    assign rif.rate = s_q.rate;
endmodule

// *** ptos_monitor.sv ***
`timescale 1ns/1ns
module ptos_monitor #(
    parameter int DW = 16
) (
    // clock and reset
    input wire logic          ref_clk,
    input wire logic          rst,
    // register port
    input wire logic          wr_stb,
    input wire logic          rd_stb,
    input wire logic [DW-1:0] rd_data,
    // sequencing
    input wire logic          block_start,
    input wire logic          block_done,
    input wire logic          cycle_start,
    input wire logic          exec_block,
    input wire logic          skip_block,
    input wire logic          auto_stop,
    // motion and echoes
    input wire logic          motion_pulse,
    input wire logic          servo_pulse,
    input wire logic          coord_pulse,
    input wire logic          block_skip_status
);
    import ptos_pkg::*;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);
    sequence s_quiet_bus;
        !wr_stb ##1 !wr_stb;
    endsequence
    sequence s_stopped_start;
        auto_stop && block_start;
    endsequence
    AST_COORD_FOLLOWS: assert property (coord_pulse == $past(motion_pulse))
        else $error("coordinate pulse does not follow motion");
    AST_SERVO_GATED: assert property (servo_pulse |-> coord_pulse)
        else $error("servo pulse without motion");
    AST_ONE_OUTCOME: assert property (exec_block |-> !skip_block)
        else $error("block both executed and skipped");
    AST_OUTCOME_CAUSE: assert property ((exec_block || skip_block) |-> $past(block_start) && !$past(auto_stop))
        else $error("block outcome without accepted start");
    AST_STOP_REFUSES: assert property (s_stopped_start |=> !exec_block && !skip_block)
        else $error("block taken while stopped");
    AST_STOP_HOLDS: assert property (auto_stop && !cycle_start |=> auto_stop)
        else $error("stop state left without cycle start");
    AST_STOP_ENTRY: assert property ($rose(auto_stop) |-> $past(block_done))
        else $error("stop entered without block end");
    AST_SKIP_ECHO_QUIET: assert property (s_quiet_bus |=> $stable(block_skip_status))
        else $error("skip echo moved without a write");
    AST_SKIP_NEEDS_ECHO: assert property (skip_block |-> block_skip_status)
        else $error("block skipped with skip off");
    AST_RD_IDLE: assert property (!$past(rd_stb) |-> rd_data == '0)
        else $error("read data outside its slot");
endmodule

bind ptos_top ptos_monitor #(.DW(DW)) u_mon (.ref_clk, .rst, .wr_stb, .rd_stb, .rd_data, .block_start,
    .block_done, .cycle_start, .exec_block, .skip_block, .auto_stop, .motion_pulse, .servo_pulse,
    .coord_pulse, .block_skip_status);

// *** ptos_plc_model.sv ***
`timescale 1ns/1ns
module ptos_plc_model (
    // clock
    input wire logic ref_clk,
    // block and motion requests
    output logic     block_start,
    output logic     block_slash,
    output logic     block_thread,
    output logic     block_done,
    output logic     motion_pulse,
    // outcome and motion seen back
    input wire logic exec_block,
    input wire logic skip_block,
    input wire logic servo_pulse,
    input wire logic coord_pulse
);
    initial begin
        block_start = 1'b0;
        block_slash = 1'b0;
        block_thread = 1'b0;
        block_done = 1'b0;
        motion_pulse = 1'b0;
    end
    // one block: present, take outcome, finish only what was executed
    task automatic run_block(input logic slash, input logic thread, output logic ex, output logic sk);
        @(posedge ref_clk);
        block_start <= 1'b1;
        block_slash <= slash;
        block_thread <= thread;
        @(posedge ref_clk);
        block_start <= 1'b0;
        block_slash <= ~slash;
        block_thread <= ~thread;
        #1;
        ex = exec_block;
        sk = skip_block;
        if (ex) begin
            @(posedge ref_clk);
            block_done <= 1'b1;
            @(posedge ref_clk);
            block_done <= 1'b0;
            #1;
        end
    endtask
    task automatic pulse_motion(output logic sv, output logic co);
        @(posedge ref_clk);
        motion_pulse <= 1'b1;
        @(posedge ref_clk);
        motion_pulse <= 1'b0;
        #1;
        sv = servo_pulse;
        co = coord_pulse;
    endtask
endmodule

// *** program_test_override_signals_tb.sv ***
`timescale 1ns/1ns
module program_test_override_signals_tb;
    import ptos_pkg::*;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  addr = 4'h0;
    logic [15:0] wr_data = 16'h0000;
    logic        wr_stb = 1'b0;
    logic        rd_stb = 1'b0;
    logic        cycle_start = 1'b0;
    logic        ce = 1'b1;
    logic        block_start, block_slash, block_thread, block_done, motion_pulse;
    logic        exec_block, skip_block, auto_stop, servo_pulse, coord_pulse;
    logic        machine_lock_status, single_block_status, block_skip_status;
    logic [15:0] rd_data, feed_rate, rapid_rate;
    int          n_fail = 0;
    int          tests_run = 0;
    always #10 ref_clk = ~ref_clk;
    ptos_top u_dut (.ref_clk, .rst, .ce, .addr, .wr_data, .wr_stb, .rd_stb, .rd_data, .block_start,
        .block_slash, .block_thread, .block_done, .cycle_start, .exec_block, .skip_block, .auto_stop,
        .motion_pulse, .servo_pulse, .coord_pulse, .feed_rate, .rapid_rate, .machine_lock_status,
        .single_block_status, .block_skip_status);
    ptos_plc_model u_plc (.ref_clk, .block_start, .block_slash, .block_thread, .block_done, .motion_pulse,
        .exec_block, .skip_block, .servo_pulse, .coord_pulse);
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        addr <= a;
        wr_data <= d;
        wr_stb <= 1'b1;
        @(posedge ref_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic reg_chk(input logic [3:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge ref_clk);
        rd_stb <= 1'b0;
        #1;
        check(rd_data, exp);
    endtask
    task automatic t_regs;
        reg_chk(OFS_RAPID_PAR, RST_RAPID_PAR);
        reg_chk(OFS_DRY_RATE, RST_DRY_RATE);
        reg_chk(OFS_LOW_RATE, RST_LOW_RATE);
        reg_chk(OFS_PROG_FEED, RST_PROG_FEED);
        for (int i = 0; i < 8; i++) reg_chk(i[3:0], {8'h00, RST_BYTE});
        reg_chk(OFS_RAMP_STEP, RST_RAMP_STEP);
        // a write while the enable is low must leave no trace
        @(posedge ref_clk);
        ce <= 1'b0;
        reg_wr(OFS_SKIP, 16'h0001);
        ce <= 1'b1;
        cycles(2);
        check({15'h0, block_skip_status}, 16'h0000);
        reg_chk(OFS_SKIP, 16'h0000);
    endtask
    task automatic t_echo;
        logic sv, co;
        reg_wr(OFS_LOCK, 16'hff01);
        reg_wr(OFS_TEST_MODE, 16'h0002);
        reg_wr(OFS_SKIP, 16'h0001);
        reg_wr(OFS_STATUS, 16'h0000);
        reg_chk(OFS_LOCK, 16'h0001);
        reg_chk(OFS_STATUS, 16'h000b);
        check({13'h0, machine_lock_status, single_block_status, block_skip_status}, 16'h0007);
        u_plc.pulse_motion(sv, co);
        check({14'h0, sv, co}, 16'h0001);
        reg_wr(OFS_LOCK, 16'h0000);
        reg_wr(OFS_TEST_MODE, 16'h0000);
        reg_wr(OFS_SKIP, 16'h0000);
        cycles(2);
        check({13'h0, machine_lock_status, single_block_status, block_skip_status}, 16'h0000);
        u_plc.pulse_motion(sv, co);
        check({14'h0, sv, co}, 16'h0003);
    endtask
    function automatic logic [15:0] rapid_exp(input logic alt, input logic [2:0] c);
        int pct;
        if (!alt && c == 3'h0) return RST_LOW_RATE;
        if (alt) pct = (c > 3'h5) ? 100 : 20 * c;
        else pct = (c == 3'h1) ? 25 : (c == 3'h2) ? 50 : 100;
        return 16'((32'(RST_RAPID_PAR) * pct) / 100);
    endfunction
    task automatic t_rapid;
        for (int a = 0; a < 2; a++) begin
            reg_wr(OFS_CANCEL, a[0] ? 16'h0010 : 16'h0000);
            for (int c = 0; c < 8; c++) begin
                reg_wr(OFS_RAPID_SEL, {8'h00, a[0], 4'h0, c[2:0]});
                cycles(2);
                check(rapid_rate, rapid_exp(a[0], c[2:0]));
            end
        end
        reg_chk(OFS_RAPID_OUT, rapid_exp(1'b1, 3'h7));
    endtask
    task automatic wait_feed(input logic [15:0] exp);
        logic [15:0] prev;
        int k;
        cycles(1);
        prev = feed_rate;
        for (k = 0; k < 300 && feed_rate !== exp; k++) begin
            cycles(1);
            if (feed_rate > prev + RST_RAMP_STEP || prev > feed_rate + RST_RAMP_STEP) check(feed_rate, prev);
            prev = feed_rate;
        end
        check(feed_rate, exp);
        if (feed_rate !== exp) tally_and_finish;
    endtask
    task automatic t_feed;
        logic [4:0] codes[4] = '{5'd1, 5'd20, 5'd31, 5'd3};
        reg_wr(OFS_CANCEL, 16'h0000);
        reg_wr(OFS_OP_MODE, {14'h0, MODE_AUTO});
        foreach (codes[i]) begin
            reg_wr(OFS_FEED_SEL, {11'h0, codes[i]});
            wait_feed(16'((32'(RST_PROG_FEED) * (codes[i] > 5'd20 ? 200 : 10 * codes[i])) / 100));
        end
        reg_wr(OFS_CANCEL, 16'h0010);
        wait_feed(RST_PROG_FEED);
        reg_wr(OFS_CANCEL, 16'h0000);
        reg_wr(OFS_DRY_RATE, 16'h0300);
        reg_wr(OFS_TEST_MODE, 16'h0080);
        wait_feed(16'h0300);
        reg_wr(OFS_OP_MODE, {14'h0, MODE_MANUAL});
        wait_feed(16'h0133);
        reg_chk(OFS_FEED_OUT, 16'h0133);
        reg_wr(OFS_TEST_MODE, 16'h0000);
    endtask
    task automatic blk(input logic slash, input logic thread, input logic [2:0] exp);
        logic ex, sk;
        u_plc.run_block(slash, thread, ex, sk);
        check({13'h0, ex, sk, auto_stop}, {13'h0, exp});
    endtask
    task automatic t_blocks;
        reg_wr(OFS_OP_MODE, {14'h0, MODE_AUTO});
        reg_wr(OFS_SKIP, 16'h0001);
        blk(1'b1, 1'b0, 3'b010);
        blk(1'b0, 1'b0, 3'b100);
        reg_wr(OFS_OP_MODE, {14'h0, MODE_MANUAL});
        blk(1'b1, 1'b0, 3'b100);
        reg_wr(OFS_OP_MODE, {14'h0, MODE_MDI});
        blk(1'b1, 1'b0, 3'b010);
        reg_wr(OFS_SKIP, 16'h0000);
        blk(1'b1, 1'b0, 3'b100);
        reg_wr(OFS_TEST_MODE, 16'h0002);
        blk(1'b0, 1'b1, 3'b100);
        blk(1'b0, 1'b0, 3'b101);
        blk(1'b0, 1'b0, 3'b001);
        reg_chk(OFS_SEQ_STATUS, 16'h0001);
        @(posedge ref_clk);
        cycle_start <= 1'b1;
        @(posedge ref_clk);
        cycle_start <= 1'b0;
        reg_wr(OFS_TEST_MODE, 16'h0000);
        blk(1'b0, 1'b0, 3'b100);
        blk(1'b0, 1'b0, 3'b100);
    endtask
    initial begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs;
        t_echo;
        t_rapid;
        t_feed;
        t_blocks;
        tally_and_finish;
    end
endmodule
